// ===== pmwc_cfg.svh
// Purpose: Constants for the power mode and wake-up controller
// Assumes: Included by bare name from the top module only
// Notes:   Offsets are APB byte addresses; reset values are field values
`ifndef PMWC_CFG_SVH
`define PMWC_CFG_SVH

`define PMWC_OFS_SCC        12'h000
`define PMWC_OFS_XTAL       12'h004
`define PMWC_OFS_FRC        12'h008
`define PMWC_OFS_STAT       12'h00c
`define PMWC_OFS_WAKE       12'h010

`define PMWC_SCC_SEL_HI     7
`define PMWC_SCC_SEL_LO     5
`define PMWC_SCC_FHS        3
`define PMWC_SCC_FKEEP      1
`define PMWC_SCC_SKEEP      0
`define PMWC_OSC_FLAG       1
`define PMWC_OSC_EN         0
`define PMWC_STAT_TO        0
`define PMWC_STAT_PDF       1
`define PMWC_STAT_SUB       4
`define PMWC_STAT_ST_LO     8

`define PMWC_SEL_RST        3'h2
`define PMWC_SEL_SUB        3'h7
`define PMWC_XTAL_EN_RST    1'h0
`define PMWC_FRC_EN_RST     1'h1

`define PMWC_XTAL_SETTLE    1024
`define PMWC_FRC_SETTLE     16
`define PMWC_SHORT_SETTLE   2

`endif

// ===== pmwc_pkg.sv
// Purpose: Types shared by the power mode and wake-up controller
// Assumes: pmwc_cfg.svh holds all numeric constants
// Notes:   State codes are visible on mode_o
package pmwc_pkg;

    typedef enum logic [2:0]
    {
        PMWC_ST_BOOT      = 3'h0,
        PMWC_ST_RUN       = 3'h1,
        PMWC_ST_SLEEP     = 3'h2,
        PMWC_ST_IDLE_SUB  = 3'h3,
        PMWC_ST_IDLE_BOTH = 3'h4,
        PMWC_ST_IDLE_FAST = 3'h5,
        PMWC_ST_WAKE      = 3'h6
    } pmwc_state_e;

    typedef enum logic [1:0]
    {
        PMWC_WK_NONE = 2'h0,
        PMWC_WK_PORT = 2'h1,
        PMWC_WK_IRQ  = 2'h2,
        PMWC_WK_WDT  = 2'h3
    } pmwc_wake_e;

endpackage

// ===== pmwc_osc_settle.sv
// Purpose: Counts oscillator edges after enable and flags settling
// Assumes: osc_tick_i is a one-cycle pulse already synchronised
// Notes:   Dropping osc_en_i restarts the count and clears the flag
`timescale 1ns/10ps
module pmwc_osc_settle #(
    parameter int unsigned LEN = 16
) (
    input  wire logic mclk_i,
    input  wire logic rst_b_i,
    input  wire logic osc_en_i,
    input  wire logic osc_tick_i,
    output logic      stable_o
);
    localparam int unsigned CW = $clog2(LEN + 1);
    localparam logic [CW-1:0] LEN_C = CW'(LEN);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          stable_q;

    if (LEN < 1)
    begin : g_chk
        $error("pmwc_osc_settle: LEN must be at least 1");
    end

    assign cnt_d    = (osc_tick_i && (cnt_q != LEN_C)) ? cnt_q + CW'(1) : cnt_q;
    assign stable_o = stable_q;

    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i || !osc_en_i)
        begin
            cnt_q    <= '0;
            stable_q <= 1'b0;
        end
        else
        begin
            cnt_q    <= cnt_d;
            stable_q <= (cnt_d == LEN_C);
        end
    end
endmodule

// ===== pmwc_top.sv
// Purpose: Operating mode, halt and wake-up controller with APB registers
// Assumes: Oscillator edges arrive as asynchronous pins; core signals on mclk_i
// Notes:   System and peripheral clocks leave as one-cycle tick pulses
`timescale 1ns/10ps
`include "pmwc_cfg.svh"
module pmwc_top
    import pmwc_pkg::*;
#(
    parameter int unsigned PORTA_W     = 8,
    parameter int unsigned IRQ_W       = 4,
    parameter int unsigned XTAL_SETTLE = `PMWC_XTAL_SETTLE,
    parameter int unsigned FRC_SETTLE  = `PMWC_FRC_SETTLE,
    parameter int unsigned SHORT_WAIT  = `PMWC_SHORT_SETTLE
) (
    input  wire logic               mclk_i,
    input  wire logic               rst_b_i,
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [11:0]        paddr_i,
    input  wire logic [31:0]        pwdata_i,
    output logic                    pready_o,
    output logic [31:0]             prdata_o,
    output logic                    pslverr_o,
    input  wire logic               halt_i,
    input  wire logic               clr_wdt_i,
    input  wire logic               wdt_en_i,
    input  wire logic               wdt_overflow_i,
    input  wire logic [IRQ_W-1:0]   irq_req_i,
    input  wire logic [IRQ_W-1:0]   irq_enable_i,
    input  wire logic               stack_full_i,
    input  wire logic [PORTA_W-1:0] porta_i,
    input  wire logic               xtal_clk_i,
    input  wire logic               frc_clk_i,
    input  wire logic               slow_clk_i,
    output logic                    core_stall_o,
    output logic                    io_hold_o,
    output logic                    wdt_clear_o,
    output logic                    pc_sp_reset_o,
    output logic                    irq_take_o,
    output logic                    resume_next_o,
    output logic                    sys_clk_tick_o,
    output logic                    fh_tick_o,
    output logic                    sub_tick_o,
    output logic                    sys_src_sub_o,
    output logic                    xtal_osc_en_o,
    output logic                    frc_osc_en_o,
    output logic                    slow_osc_en_o,
    output logic [2:0]              mode_o
);
    if (PORTA_W < 1 || PORTA_W > 8 || IRQ_W < 1 || IRQ_W > 16)
    begin : g_chk
        $error("pmwc_top: PORTA_W must be 1..8 and IRQ_W 1..16");
    end

    // Registers
    pmwc_state_e          state_q;
    pmwc_state_e          state_d;
    pmwc_state_e          from_q;
    pmwc_wake_e           cause_q;
    logic [2:0]           sel_q;
    logic                 fhs_q;
    logic                 fkeep_q;
    logic                 skeep_q;
    logic                 xtal_en_q;
    logic                 frc_en_q;
    logic [PORTA_W-1:0]   wake_en_q;
    logic                 pdf_q;
    logic                 to_q;
    logic                 sub_q;
    logic [5:0]           div_q;
    logic [IRQ_W-1:0]     irq_block_q;
    logic [31:0]          prdata_q;
    logic                 wdt_clear_q;
    logic                 pc_sp_reset_q;
    logic                 irq_take_q;
    logic                 resume_q;
    logic                 sys_tick_q;
    logic                 fh_tick_q;
    logic                 sub_tick_q;
    // Pin synchronisers: stage 1 feeds stage 2 only; stage 3 is for edges
    logic [2:0]           osc_s1_q;
    logic [2:0]           osc_s2_q;
    logic [2:0]           osc_s3_q;
    logic [PORTA_W-1:0]   pa_s1_q;
    logic [PORTA_W-1:0]   pa_s2_q;
    logic [PORTA_W-1:0]   pa_s3_q;

    // Decode
    wire        apb_setup   = psel_i && !penable_i;
    wire        apb_access  = psel_i && penable_i;
    wire        apb_wr      = apb_access && pwrite_i;
    wire        hit_scc     = (paddr_i == `PMWC_OFS_SCC);
    wire        hit_xtal    = (paddr_i == `PMWC_OFS_XTAL);
    wire        hit_frc     = (paddr_i == `PMWC_OFS_FRC);
    wire        hit_stat    = (paddr_i == `PMWC_OFS_STAT);
    wire        hit_wake    = (paddr_i == `PMWC_OFS_WAKE);
    wire        hit_any     = hit_scc || hit_xtal || hit_frc || hit_stat || hit_wake;

    wire        xtal_tick   = osc_s2_q[0] && !osc_s3_q[0];
    wire        frc_tick    = osc_s2_q[1] && !osc_s3_q[1];
    wire        slow_tick   = osc_s2_q[2] && !osc_s3_q[2];
    wire        fast_tick   = fhs_q ? xtal_tick : frc_tick;

    wire        st_run      = (state_q == PMWC_ST_RUN);
    wire        st_boot     = (state_q == PMWC_ST_BOOT);
    wire        st_wake     = (state_q == PMWC_ST_WAKE);
    wire        st_down     = !st_run && !st_boot && !st_wake;
    wire        halt_take   = st_run && halt_i;

    // Oscillator supply per state; slow RC also stays up for the watchdog
    wire        fast_run    = !st_down || fkeep_q;
    wire        slow_run    = !st_down || skeep_q || wdt_en_i;
    wire        xtal_on     = xtal_en_q && fast_run;
    wire        frc_on      = frc_en_q && fast_run;

    wire        xtal_stable;
    wire        frc_stable;
    wire        slow_stable;
    wire        short_done;
    wire        fast_stable = fhs_q ? xtal_stable : frc_stable;

    // Divider mask: 2^sel - 1 for codes 0..6
    wire [5:0]  div_mask    = 6'h3f >> (3'h6 - sel_q);
    wire        div_hit     = ((div_q | ~div_mask) == 6'h3f);

    wire        sys_on      = (state_q == PMWC_ST_SLEEP)     ? 1'b0 :
                              (state_q == PMWC_ST_IDLE_SUB)  ? sub_q :
                              (state_q == PMWC_ST_IDLE_FAST) ? !sub_q : 1'b1;
    wire        fh_on       = (state_q == PMWC_ST_SLEEP) ? 1'b0 :
                              (state_q == PMWC_ST_IDLE_SUB) ? 1'b0 : 1'b1;
    wire        sub_on      = (state_q != PMWC_ST_IDLE_FAST);
    wire        sys_src_tk  = sub_q ? slow_tick : (fast_tick && div_hit);

    // Wake sources
    wire [PORTA_W-1:0] pa_fall  = pa_s3_q & ~pa_s2_q & wake_en_q;
    wire [IRQ_W-1:0]   irq_new  = irq_req_i & ~irq_block_q;
    wire        wk_port     = |pa_fall;
    wire        wk_irq      = |irq_new;
    wire        wk_any      = wk_port || wk_irq || wdt_overflow_i;
    wire        irq_serve   = |(irq_new & irq_enable_i) && !stack_full_i;
    wire        slow_wake   = (from_q == PMWC_ST_SLEEP) || (from_q == PMWC_ST_IDLE_SUB);
    wire        wake_done   = (slow_wake && !sub_q) ? fast_stable : short_done;
    wire        short_tick  = sub_q ? slow_tick : fast_tick;

    wire [31:0] rd_scc      = {24'h0, sel_q, 1'b0, fhs_q, 1'b0, fkeep_q, skeep_q};
    wire [31:0] rd_xtal     = {30'h0, xtal_stable, xtal_en_q};
    wire [31:0] rd_frc      = {30'h0, frc_stable, frc_en_q};
    wire [31:0] rd_stat     = {21'h0, state_q, 3'h0, sub_q, 2'h0, pdf_q, to_q};
    wire [31:0] rd_wake     = {{(32-PORTA_W){1'b0}}, wake_en_q};
    wire [31:0] rd_mux      = hit_scc  ? rd_scc  :
                              hit_xtal ? rd_xtal :
                              hit_frc  ? rd_frc  :
                              hit_stat ? rd_stat :
                              hit_wake ? rd_wake : 32'h0;

    assign pready_o       = 1'b1;
    assign pslverr_o      = apb_access && !hit_any;
    assign prdata_o       = prdata_q;
    assign core_stall_o   = !st_run;
    assign io_hold_o      = st_down;
    assign wdt_clear_o    = wdt_clear_q;
    assign pc_sp_reset_o  = pc_sp_reset_q;
    assign irq_take_o     = irq_take_q;
    assign resume_next_o  = resume_q;
    assign sys_clk_tick_o = sys_tick_q;
    assign fh_tick_o      = fh_tick_q;
    assign sub_tick_o     = sub_tick_q;
    assign sys_src_sub_o  = sub_q;
    assign xtal_osc_en_o  = xtal_on;
    assign frc_osc_en_o   = frc_on;
    assign slow_osc_en_o  = slow_run;
    assign mode_o         = state_q;

    // Settling counters restart whenever the oscillator is off
    pmwc_osc_settle #(.LEN(XTAL_SETTLE)) u_xtal_settle
    (
        .mclk_i     (mclk_i),
        .rst_b_i    (rst_b_i),
        .osc_en_i   (xtal_on),
        .osc_tick_i (xtal_tick),
        .stable_o   (xtal_stable)
    );

    pmwc_osc_settle #(.LEN(FRC_SETTLE)) u_frc_settle
    (
        .mclk_i     (mclk_i),
        .rst_b_i    (rst_b_i),
        .osc_en_i   (frc_on),
        .osc_tick_i (frc_tick),
        .stable_o   (frc_stable)
    );

    pmwc_osc_settle #(.LEN(SHORT_WAIT)) u_slow_settle
    (
        .mclk_i     (mclk_i),
        .rst_b_i    (rst_b_i),
        .osc_en_i   (slow_run),
        .osc_tick_i (slow_tick),
        .stable_o   (slow_stable)
    );

    // Short wake delay counts edges of whichever oscillator drives the system
    pmwc_osc_settle #(.LEN(SHORT_WAIT)) u_wake_short
    (
        .mclk_i     (mclk_i),
        .rst_b_i    (rst_b_i),
        .osc_en_i   (st_wake),
        .osc_tick_i (short_tick),
        .stable_o   (short_done)
    );

    // Mode sequencing
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            PMWC_ST_BOOT:
            begin
                if (fast_stable)
                begin
                    state_d = PMWC_ST_RUN;
                end
            end
            PMWC_ST_RUN:
            begin
                if (halt_i)
                begin
                    unique case ({fkeep_q, skeep_q})
                        2'b00:   state_d = PMWC_ST_SLEEP;
                        2'b01:   state_d = PMWC_ST_IDLE_SUB;
                        2'b11:   state_d = PMWC_ST_IDLE_BOTH;
                        2'b10:   state_d = PMWC_ST_IDLE_FAST;
                    endcase
                end
            end
            PMWC_ST_SLEEP, PMWC_ST_IDLE_SUB, PMWC_ST_IDLE_BOTH, PMWC_ST_IDLE_FAST:
            begin
                if (wk_any)
                begin
                    state_d = PMWC_ST_WAKE;
                end
            end
            PMWC_ST_WAKE:
            begin
                if (wake_done)
                begin
                    state_d = PMWC_ST_RUN;
                end
            end
            default:
            begin
                state_d = PMWC_ST_BOOT;
            end
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            state_q     <= PMWC_ST_BOOT;
            from_q      <= PMWC_ST_BOOT;
            cause_q     <= PMWC_WK_NONE;
            irq_block_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            if (halt_take)
            begin
                from_q      <= state_d;
                irq_block_q <= irq_req_i;
            end
            if (st_down && wk_any)
            begin
                cause_q <= pmwc_wake_e'(wdt_overflow_i ? PMWC_WK_WDT :
                                        wk_irq         ? PMWC_WK_IRQ : PMWC_WK_PORT);
            end
        end
    end

    // Core-facing pulses issue as the wake delay ends
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            pc_sp_reset_q <= 1'b0;
            irq_take_q    <= 1'b0;
            resume_q      <= 1'b0;
            wdt_clear_q   <= 1'b0;
        end
        else
        begin
            pc_sp_reset_q <= st_wake && wake_done && (cause_q == PMWC_WK_WDT);
            irq_take_q    <= st_wake && wake_done && (cause_q == PMWC_WK_IRQ)
                             && irq_serve;
            resume_q      <= st_wake && wake_done && ((cause_q == PMWC_WK_PORT) ||
                             ((cause_q == PMWC_WK_IRQ) && !irq_serve));
            wdt_clear_q   <= halt_take || clr_wdt_i;
        end
    end

    // Status flags; a set in the same cycle as a clear wins
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            pdf_q <= 1'b0;
            to_q  <= 1'b0;
        end
        else
        begin
            pdf_q <= halt_take || (pdf_q && !clr_wdt_i);
            to_q  <= wdt_overflow_i || (to_q && !halt_take);
        end
    end

    // Clock source selection; the old source keeps running until the new one is ready
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            sub_q <= 1'b0;
        end
        else if (!sub_q && (sel_q == `PMWC_SEL_SUB) && slow_stable)
        begin
            sub_q <= 1'b1;
        end
        else if (sub_q && (sel_q != `PMWC_SEL_SUB) && fast_stable)
        begin
            sub_q <= 1'b0;
        end
    end

    // Divider runs freely so a ratio change takes effect at the next boundary
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            div_q      <= 6'h0;
            sys_tick_q <= 1'b0;
            fh_tick_q  <= 1'b0;
            sub_tick_q <= 1'b0;
        end
        else
        begin
            div_q      <= fast_tick ? div_q + 6'h1 : div_q;
            sys_tick_q <= sys_on && sys_src_tk;
            fh_tick_q  <= fh_on && fast_tick;
            sub_tick_q <= sub_on && slow_tick;
        end
    end

    // Pin synchronisers
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            osc_s1_q <= 3'h0;
            osc_s2_q <= 3'h0;
            osc_s3_q <= 3'h0;
            pa_s1_q  <= '1;
            pa_s2_q  <= '1;
            pa_s3_q  <= '1;
        end
        else
        begin
            osc_s1_q <= {slow_clk_i, frc_clk_i, xtal_clk_i};
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
            pa_s1_q  <= porta_i;
            pa_s2_q  <= pa_s1_q;
            pa_s3_q  <= pa_s2_q;
        end
    end

    // APB registers
    always_ff @(posedge mclk_i)
    begin
        if (!rst_b_i)
        begin
            sel_q     <= `PMWC_SEL_RST;
            fhs_q     <= 1'b0;
            fkeep_q   <= 1'b0;
            skeep_q   <= 1'b0;
            xtal_en_q <= `PMWC_XTAL_EN_RST;
            frc_en_q  <= `PMWC_FRC_EN_RST;
            wake_en_q <= '0;
            prdata_q  <= 32'h0;
        end
        else
        begin
            if (apb_setup)
            begin
                prdata_q <= pwrite_i ? 32'h0 : rd_mux;
            end
            if (apb_wr && hit_scc)
            begin
                sel_q   <= pwdata_i[`PMWC_SCC_SEL_HI:`PMWC_SCC_SEL_LO];
                fhs_q   <= pwdata_i[`PMWC_SCC_FHS];
                fkeep_q <= pwdata_i[`PMWC_SCC_FKEEP];
                skeep_q <= pwdata_i[`PMWC_SCC_SKEEP];
            end
            if (apb_wr && hit_xtal)
            begin
                xtal_en_q <= pwdata_i[`PMWC_OSC_EN];
            end
            if (apb_wr && hit_frc)
            begin
                frc_en_q <= pwdata_i[`PMWC_OSC_EN];
            end
            if (apb_wr && hit_wake)
            begin
                wake_en_q <= pwdata_i[PORTA_W-1:0];
            end
        end
    end
endmodule

// ===== pmwc_monitor.sv
// Purpose: Port-level assertions for the power mode controller
// Assumes: Bound to pmwc_top; one clock domain
// Notes:   Sleep and idle tick checks skip entry cycles, where an old edge may be in flight
`timescale 1ns/10ps
module pmwc_monitor (
    input wire logic       mclk_i,
    input wire logic       rst_b_i,
    input wire logic       halt_i,
    input wire logic       clr_wdt_i,
    input wire logic       core_stall_o,
    input wire logic       io_hold_o,
    input wire logic       wdt_clear_o,
    input wire logic       pc_sp_reset_o,
    input wire logic       irq_take_o,
    input wire logic       resume_next_o,
    input wire logic       sys_clk_tick_o,
    input wire logic       fh_tick_o,
    input wire logic       sub_tick_o,
    input wire logic       sys_src_sub_o,
    input wire logic [2:0] mode_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);
    wire [2:0] pulse_w = {pc_sp_reset_o, irq_take_o, resume_next_o};
    sequence halt_taken_s;
        halt_i && mode_o == 3'h1;
    endsequence
    // Any cycle in run mode follows boot, run or wake, where both tick gates are open
    sequence sub_run_s;
        mode_o == 3'h1 && $past(sys_src_sub_o);
    endsequence
    sequence wake_done_s;
        mode_o == 3'h6 ##1 mode_o == 3'h1;
    endsequence

    stall_mode_a: assert property (core_stall_o == (mode_o != 3'h1))
        else $error("stall does not follow mode");
    hold_down_a: assert property (io_hold_o == (mode_o inside {[3'h2:3'h5]}))
        else $error("io hold does not follow mode");
    halt_entry_a: assert property (halt_taken_s |=> mode_o inside {[3'h2:3'h5]} && wdt_clear_o)
        else $error("halt not taken with watchdog clear");
    clr_wdt_a: assert property (clr_wdt_i |=> wdt_clear_o)
        else $error("clear instruction lost");
    wake_pulse_a: assert property (wake_done_s |-> ##[0:1] $onehot(pulse_w))
        else $error("wake without resume pulse");
    pulse_single_a: assert property ($onehot0(pulse_w))
        else $error("two resume pulses at once");
    pulse_run_a: assert property (pulse_w != 3'h0 |-> mode_o == 3'h1)
        else $error("resume pulse outside run");
    sleep_tick_a: assert property (mode_o == 3'h2 && $past(mode_o, 4) == 3'h2 |-> !sys_clk_tick_o)
        else $error("system tick in sleep");
    idle_sub_a: assert property (mode_o == 3'h3 && $past(mode_o, 4) == 3'h3 |-> !fh_tick_o)
        else $error("fast tick in sub-only idle");
    idle_fast_a: assert property (mode_o == 3'h5 && $past(mode_o, 4) == 3'h5 |-> !sub_tick_o)
        else $error("sub tick in fast-only idle");
    sys_sub_a: assert property (sub_run_s |-> sys_clk_tick_o == sub_tick_o)
        else $error("system tick not on sub clock");
endmodule

bind pmwc_top pmwc_monitor u_mon (.*);

// ===== pmwc_osc_model.sv
// Purpose: Oscillator stand-in for crystal, fast RC and slow RC pins
// Assumes: Bit order {crystal, fast RC, slow RC}; HALF is each half period less one, in mclk
// Notes:   A disabled oscillator stands low and restarts from scratch
`timescale 1ns/10ps
module pmwc_osc_model (
    input  wire logic       mclk_i,
    input  wire logic [2:0] en_i,
    output logic [2:0]      clk_o
);
    localparam int HALF [3] = '{5, 3, 2};
    int cnt [3];

    initial clk_o = 3'h0;
    always @(posedge mclk_i)
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (!en_i[i])
            begin
                cnt[i] <= 0;
                clk_o[i] <= 1'b0;
            end
            else if (cnt[i] >= HALF[i])
            begin
                cnt[i] <= 0;
                clk_o[i] <= ~clk_o[i];
            end
            else
                cnt[i] <= cnt[i] + 1;
        end
    end
endmodule

// ===== tb_top.sv
// Purpose: Self-checking bench for the power mode controller
// Assumes: Settle counts shortened; APB answers within 50 cycles
// Notes:   Wake delays are bounded here, not measured
`timescale 1ns/10ps
module tb_top;
    logic        mclk_i, rst_b_i, psel_i, penable_i, pwrite_i, halt_i, clr_wdt_i;
    logic        wdt_en_i, wdt_overflow_i, stack_full_i, xtal_clk_i, frc_clk_i, slow_clk_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic [3:0]  irq_req_i, irq_enable_i;
    logic [7:0]  porta_i;
    logic [2:0]  mode_o, osc_clk;
    logic        pready_o, pslverr_o, core_stall_o, io_hold_o, wdt_clear_o, pc_sp_reset_o;
    logic        irq_take_o, resume_next_o, sys_clk_tick_o, fh_tick_o, sub_tick_o, er;
    logic        sys_src_sub_o, xtal_osc_en_o, frc_osc_en_o, slow_osc_en_o;
    logic [2:0]  modes [4] = '{3'h2, 3'h3, 3'h5, 3'h4};
    int          fail_count = 0;
    int          n_checks = 0;
    int          n_wake;
    wire  [2:0]  pulse_w = {pc_sp_reset_o, irq_take_o, resume_next_o};

    assign {xtal_clk_i, frc_clk_i, slow_clk_i} = osc_clk;
    pmwc_top #(.XTAL_SETTLE(8), .FRC_SETTLE(4), .SHORT_WAIT(2)) uut (.*);
    pmwc_osc_model osc (
        .mclk_i (mclk_i),
        .en_i   ({xtal_osc_en_o, frc_osc_en_o, slow_osc_en_o}),
        .clk_o  (osc_clk)
    );

    task automatic finish_test;
        if (fail_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic give_up;
        $display("[ERR] %0t wait ran out", $time);
        fail_count++;
        finish_test;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Request held until pready is sampled; an idle edge keeps psel from double assignment
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel_i   <= 1'b1;
        pwrite_i <= w;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        n = 0;
        do
        begin
            @(posedge mclk_i);
            n++;
        end
        while (pready_o !== 1'b1 && n < 50);
        if (pready_o !== 1'b1)
            give_up;
        rd = prdata_o;
        er = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    task automatic wait_for(input int s, input logic [2:0] v);
        int n;
        n = 0;
        while ((s == 0 ? mode_o : s == 1 ? pulse_w : {2'h0, sys_src_sub_o}) !== v && n < 9000)
        begin
            @(posedge mclk_i);
            n++;
        end
        if (n == 9000)
            give_up;
    endtask
    task automatic halt(input logic [31:0] system_clock_ctrl_reg, input logic [2:0] m);
        apb(1'b1, 12'h000, system_clock_ctrl_reg);
        halt_i <= 1'b1;
        @(posedge mclk_i);
        halt_i <= 1'b0;
        @(posedge mclk_i);
        check({29'h0, mode_o}, {29'h0, m});
        check({31'h0, io_hold_o}, 32'h1);
    endtask

    initial
    begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end

    initial
    begin
        {rst_b_i, psel_i, penable_i, pwrite_i, halt_i, clr_wdt_i} = '0;
        {wdt_en_i, wdt_overflow_i, stack_full_i} = '0;
        {paddr_i, pwdata_i, irq_req_i, irq_enable_i} = '0;
        porta_i = 8'hff;
        repeat (5) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        wait_for(0, 3'h1);
        rdc(12'h000, 32'h40);
        rdc(12'h004, 32'h0);
        rdc(12'h008, 32'h3);
        rdc(12'h020, 32'h0);
        check({31'h0, er}, 32'h1);
        apb(1'b1, 12'h010, 32'h1);
        for (int k = 0; k < 4; k++)
        begin
            halt(32'h40 | k, modes[k]);
            check({30'h0, frc_osc_en_o, slow_osc_en_o}, {30'h0, k[1:0]});
            rdc(12'h00c, {21'h0, modes[k], 8'h02});
            porta_i <= 8'hfe;
            wait_for(1, 3'h1);
            porta_i <= 8'hff;
        end
        irq_enable_i <= 4'h1;
        irq_req_i <= 4'h1;
        halt(32'h40, 3'h2);
        porta_i <= 8'hfd;
        repeat (60) @(posedge mclk_i);
        check({29'h0, mode_o}, 32'h2);
        porta_i <= 8'hfc;
        wait_for(1, 3'h1);
        porta_i <= 8'hff;
        irq_req_i <= 4'h0;
        for (int i = 0; i < 3; i++)
        begin
            irq_enable_i <= {3'h0, i != 1};
            stack_full_i <= (i == 2);
            halt(32'h40, 3'h2);
            irq_req_i <= 4'h1;
            wait_for(1, i == 0 ? 3'h2 : 3'h1);
            irq_req_i <= 4'h0;
        end
        halt(32'h40, 3'h2);
        wdt_overflow_i <= 1'b1;
        @(posedge mclk_i);
        wdt_overflow_i <= 1'b0;
        wait_for(1, 3'h4);
        rdc(12'h00c, 32'h103);
        clr_wdt_i <= 1'b1;
        @(posedge mclk_i);
        clr_wdt_i <= 1'b0;
        @(posedge mclk_i);
        rdc(12'h00c, 32'h101);
        apb(1'b1, 12'h000, 32'he0);
        wait_for(2, 3'h1);
        rdc(12'h00c, 32'h111);
        repeat (30) @(posedge mclk_i);
        apb(1'b1, 12'h000, 32'h0);
        wait_for(2, 3'h0);
        apb(1'b1, 12'h004, 32'h1);
        rdc(12'h004, 32'h1);
        halt(32'h08, 3'h2);
        porta_i <= 8'hfe;
        wait_for(0, 3'h6);
        // Crystal restarts from off: 8 edges of a 6-cycle period cannot pass in 42 cycles
        n_wake = 0;
        while (mode_o == 3'h6 && n_wake < 9000)
        begin
            @(posedge mclk_i);
            n_wake++;
        end
        check({31'h0, n_wake >= 42}, 32'h1);
        wait_for(1, 3'h1);
        porta_i <= 8'hff;
        rdc(12'h004, 32'h3);
        finish_test;
    end
endmodule
